// file: bkc_pkg.sv
package bkc_pkg;

   // Register map of the first step-down regulator option bank
   localparam int BKC_ADDR_W = 8;
   localparam int BKC_DATA_W = 8;
   localparam logic [BKC_ADDR_W-1:0] BKC_LOOP_OFFSET = 8'h1c;
   localparam logic [BKC_ADDR_W-1:0] BKC_MODE_OFFSET = 8'h1d;
   localparam logic [BKC_ADDR_W-1:0] BKC_PEAK_OFFSET = 8'h1e;

   // Values after reset
   localparam logic [BKC_DATA_W-1:0] BKC_LOOP_RESET = 8'h00;
   localparam logic [BKC_DATA_W-1:0] BKC_MODE_RESET = 8'h00;
   localparam logic [BKC_DATA_W-1:0] BKC_PEAK_RESET = 8'h00;

   // Writable bits of each register; all other bits store nothing
   localparam logic [BKC_DATA_W-1:0] BKC_LOOP_MASK = 8'hff;
   localparam logic [BKC_DATA_W-1:0] BKC_MODE_MASK = 8'h38;
   localparam logic [BKC_DATA_W-1:0] BKC_PEAK_MASK = 8'h8f;

   // Loop option register fields
   localparam int BKC_INTEG_OFF_BIT = 7;
   localparam int BKC_PGOOD_BIT = 6;
   localparam int BKC_FAST_BIT = 5;
   localparam int BKC_PSV_DSC_BIT = 4;
   localparam int BKC_ACT_DSC_BIT = 3;
   localparam int BKC_SLOW_EDGE_BIT = 2;
   localparam int BKC_HALVING_BIT = 1;
   localparam int BKC_NODE_SENSE_BIT = 0;

   // Mode option register fields
   localparam int BKC_PIN_FAST_BIT = 5;
   localparam int BKC_FPWM_BIT = 4;
   localparam int BKC_ADAPT_OFF_BIT = 3;

   // Peak current register fields
   localparam int BKC_TABLE_BYPASS_BIT = 7;
   localparam int BKC_PEAK_CODE_MSB = 3;
   localparam int BKC_PEAK_CODE_LSB = 0;
   localparam int BKC_PEAK_STEP_MA = 25;

   // Enable resolution
   localparam logic [2:0] BKC_SEQ_SOFTWARE = 3'h7;
   localparam logic [1:0] BKC_EN_OFF = 2'h0;
   localparam logic [1:0] BKC_EN_ON = 2'h1;
   localparam logic [1:0] BKC_EN_PIN = 2'h2;

   // Cycles from a read strobe to its data
   localparam int BKC_READ_LATENCY = 1;

   typedef enum logic [1:0] {
      BKC_REG_LOOP,
      BKC_REG_MODE,
      BKC_REG_PEAK,
      BKC_REG_NONE
   } bkc_reg_sel_t;

endpackage

// file: bkc_enable_resolve.sv
`timescale 1ns/1ps
module bkc_enable_resolve (
   input wire logic clk,                            // Register clock
   input wire logic rst_n,                          // Synchronous reset
   input wire logic [2:0] sequencing_select,        // Sequencing field
   input wire logic [1:0] regulator_enable_field,   // Software enable field
   input wire logic boot_enable,                    // Enable from boot sequence
   input wire logic pin_enable,                     // OR of selected pins
   output logic regulator_enable                    // Resolved enable
);
   import bkc_pkg::*;

   logic next_regulator_enable;

   always_comb begin
      next_regulator_enable = boot_enable;
      if (sequencing_select == BKC_SEQ_SOFTWARE) begin
         unique case (regulator_enable_field)
            BKC_EN_ON: next_regulator_enable = 1'b1;
            BKC_EN_PIN: next_regulator_enable = pin_enable;
            // Off and the reserved code both leave the regulator off
            default: next_regulator_enable = 1'b0;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         regulator_enable <= 1'b0;
      end else begin
         regulator_enable <= next_regulator_enable;
      end
   end

   a_enable_follows_boot: assert property (
      @(posedge clk) disable iff (!rst_n)
      sequencing_select != BKC_SEQ_SOFTWARE
      |=> regulator_enable == $past(boot_enable))
      else $error("enable does not follow boot sequence");

   a_enable_software_on: assert property (
      @(posedge clk) disable iff (!rst_n)
      sequencing_select == BKC_SEQ_SOFTWARE
      && regulator_enable_field == BKC_EN_ON |=> regulator_enable)
      else $error("software enable not honoured");

   a_enable_software_off: assert property (
      @(posedge clk) disable iff (!rst_n)
      sequencing_select == BKC_SEQ_SOFTWARE
      && regulator_enable_field == BKC_EN_OFF |=> !regulator_enable)
      else $error("software disable not honoured");

   a_enable_by_pin: assert property (
      @(posedge clk) disable iff (!rst_n)
      sequencing_select == BKC_SEQ_SOFTWARE
      && regulator_enable_field == BKC_EN_PIN
      |=> regulator_enable == $past(pin_enable))
      else $error("pin enable not honoured");

endmodule

// file: bkc_config_regs.sv
`timescale 1ns/1ps
module bkc_config_regs (
   input wire logic clk,                                 // Register clock
   input wire logic rst_n,                               // Synchronous reset
   input wire logic [bkc_pkg::BKC_ADDR_W-1:0] reg_addr,  // Register address
   input wire logic reg_wr,                              // Write strobe
   input wire logic [bkc_pkg::BKC_DATA_W-1:0] reg_wdata, // Write data
   input wire logic reg_rd,                              // Read strobe
   output logic [bkc_pkg::BKC_DATA_W-1:0] reg_rdata,     // Read data
   output logic reg_rvalid,                              // Read data valid
   input wire logic hard_reset,                          // Device hard reset
   input wire logic [2:0] sequencing_select,             // Sequencing field
   input wire logic [1:0] regulator_enable_field,        // Enable field
   input wire logic boot_enable,                         // Boot sequence enable
   input wire logic pin_enable,                          // OR of enable pins
   input wire logic multipurpose_input_two,              // Second pin input
   output logic integrator_off,                          // Integrator removed
   output logic power_good_during_transition,            // Comparator kept on
   output logic fast_pretrigger,                         // Fast bit as stored
   output logic fast_mode,                               // Fast mode in force
   output logic passive_discharge,                       // Passive discharge
   output logic active_discharge,                        // Active discharge
   output logic slow_edge_select,                        // Slowed edges
   output logic switch_halving,                          // Half switch size
   output logic freewheel_node_sense,                    // Wait for node high
   output logic pin_two_fast_control,                    // Pin drives fast
   output logic forced_pwm,                              // Continuous PWM
   output logic adaptive_peak_off,                       // Fixed peak current
   output logic peak_table_bypass,                       // Use code, no table
   output logic [3:0] peak_current_code,                 // Peak current code
   output logic regulator_enable                         // Resolved enable
);
   import bkc_pkg::*;

   logic [BKC_DATA_W-1:0] buck_one_loop_options;
   logic [BKC_DATA_W-1:0] buck_one_mode_options;
   logic [BKC_DATA_W-1:0] buck_one_peak_current;
   logic [BKC_DATA_W-1:0] next_rdata;
   logic next_passive_discharge;
   logic next_active_discharge;
   logic next_fast_mode;

   function automatic bkc_reg_sel_t decode_addr(
      input logic [BKC_ADDR_W-1:0] addr
   );
      bkc_reg_sel_t sel;
      sel = BKC_REG_NONE;
      if (addr == BKC_LOOP_OFFSET) begin
         sel = BKC_REG_LOOP;
      end else if (addr == BKC_MODE_OFFSET) begin
         sel = BKC_REG_MODE;
      end else if (addr == BKC_PEAK_OFFSET) begin
         sel = BKC_REG_PEAK;
      end
      return sel;
   endfunction

   // Every field is a plain flop bit; direct field outputs change on the write edge, fast mode and discharge one cycle later
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         buck_one_loop_options <= BKC_LOOP_RESET;
      end else if (reg_wr && decode_addr(reg_addr) == BKC_REG_LOOP) begin
         buck_one_loop_options <= reg_wdata & BKC_LOOP_MASK;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         buck_one_mode_options <= BKC_MODE_RESET;
      end else if (reg_wr && decode_addr(reg_addr) == BKC_REG_MODE) begin
         buck_one_mode_options <= reg_wdata & BKC_MODE_MASK;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         buck_one_peak_current <= BKC_PEAK_RESET;
      end else if (reg_wr && decode_addr(reg_addr) == BKC_REG_PEAK) begin
         buck_one_peak_current <= reg_wdata & BKC_PEAK_MASK;
      end
   end

   // Field outputs come straight from the register flops
   assign integrator_off = buck_one_loop_options[BKC_INTEG_OFF_BIT];
   assign power_good_during_transition =
      buck_one_loop_options[BKC_PGOOD_BIT];
   assign fast_pretrigger = buck_one_loop_options[BKC_FAST_BIT];
   assign slow_edge_select =
      buck_one_loop_options[BKC_SLOW_EDGE_BIT];
   assign switch_halving = buck_one_loop_options[BKC_HALVING_BIT];
   assign freewheel_node_sense =
      buck_one_loop_options[BKC_NODE_SENSE_BIT];
   assign pin_two_fast_control =
      buck_one_mode_options[BKC_PIN_FAST_BIT];
   assign forced_pwm = buck_one_mode_options[BKC_FPWM_BIT];
   assign adaptive_peak_off =
      buck_one_mode_options[BKC_ADAPT_OFF_BIT];
   assign peak_table_bypass =
      buck_one_peak_current[BKC_TABLE_BYPASS_BIT];
   // The code is passed even when the table is in use; the stage ignores it
   assign peak_current_code =
      buck_one_peak_current[BKC_PEAK_CODE_MSB:BKC_PEAK_CODE_LSB];

   bkc_enable_resolve u_enable (
      .clk(clk),
      .rst_n(rst_n),
      .sequencing_select(sequencing_select),
      .regulator_enable_field(regulator_enable_field),
      .boot_enable(boot_enable),
      .pin_enable(pin_enable),
      .regulator_enable(regulator_enable)
   );

   always_comb begin
      next_passive_discharge = hard_reset
         | (buck_one_loop_options[BKC_PSV_DSC_BIT]
            & ~regulator_enable);
      next_active_discharge = hard_reset
         | (buck_one_loop_options[BKC_ACT_DSC_BIT]
            & ~regulator_enable);
      next_fast_mode = buck_one_loop_options[BKC_FAST_BIT]
         | (buck_one_mode_options[BKC_PIN_FAST_BIT]
            & multipurpose_input_two);
   end

   // Discharge is held on through reset so the output never floats high
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         passive_discharge <= 1'b1;
         active_discharge <= 1'b1;
      end else begin
         passive_discharge <= next_passive_discharge;
         active_discharge <= next_active_discharge;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         fast_mode <= 1'b0;
      end else begin
         fast_mode <= next_fast_mode;
      end
   end

   always_comb begin
      unique case (decode_addr(reg_addr))
         BKC_REG_LOOP: next_rdata = buck_one_loop_options;
         BKC_REG_MODE: next_rdata = buck_one_mode_options;
         BKC_REG_PEAK: next_rdata = buck_one_peak_current;
         BKC_REG_NONE: next_rdata = '0;
      endcase
   end

   // Unmapped reads return zero; data holds until the next read
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         reg_rdata <= '0;
         reg_rvalid <= 1'b0;
      end else begin
         reg_rvalid <= reg_rd;
         if (reg_rd) begin
            reg_rdata <= next_rdata;
         end
      end
   end

   a_integ_write: assert property (
      @(posedge clk) disable iff (!rst_n)
      reg_wr && reg_addr == BKC_LOOP_OFFSET
      |=> integrator_off == $past(reg_wdata[BKC_INTEG_OFF_BIT]))
      else $error("integrator control not updated by write");

   a_pgood_write: assert property (
      @(posedge clk) disable iff (!rst_n)
      reg_wr && reg_addr == BKC_LOOP_OFFSET
      |=> power_good_during_transition == $past(reg_wdata[BKC_PGOOD_BIT]))
      else $error("power-good control not updated by write");

   a_fast_write: assert property (
      @(posedge clk) disable iff (!rst_n)
      reg_wr && reg_addr == BKC_LOOP_OFFSET && reg_wdata[BKC_FAST_BIT]
      |=> fast_pretrigger ##1 fast_mode)
      else $error("fast pretrigger not applied");

   a_passive_hard_reset: assert property (
      @(posedge clk) disable iff (!rst_n)
      hard_reset |=> passive_discharge)
      else $error("passive discharge missing in hard reset");

   a_passive_disabled: assert property (
      @(posedge clk) disable iff (!rst_n)
      !hard_reset && !regulator_enable
      |=> passive_discharge == $past(buck_one_loop_options[BKC_PSV_DSC_BIT]))
      else $error("passive discharge wrong while disabled");

   a_active_hard_reset: assert property (
      @(posedge clk) disable iff (!rst_n)
      hard_reset |=> active_discharge)
      else $error("active discharge missing in hard reset");

   a_active_enabled: assert property (
      @(posedge clk) disable iff (!rst_n)
      !hard_reset && regulator_enable |=> !active_discharge)
      else $error("active discharge while enabled");

   a_active_disabled: assert property (
      @(posedge clk) disable iff (!rst_n)
      !hard_reset && !regulator_enable
      |=> active_discharge == $past(buck_one_loop_options[BKC_ACT_DSC_BIT]))
      else $error("active discharge wrong while disabled");

   a_passive_enabled: assert property (
      @(posedge clk) disable iff (!rst_n)
      !hard_reset && regulator_enable |=> !passive_discharge)
      else $error("passive discharge while enabled");

   a_edge_write: assert property (
      @(posedge clk) disable iff (!rst_n)
      reg_wr && reg_addr == BKC_LOOP_OFFSET
      |=> slow_edge_select == $past(reg_wdata[BKC_SLOW_EDGE_BIT])
      && switch_halving == $past(reg_wdata[BKC_HALVING_BIT]))
      else $error("edge or scaling control not updated");

   a_sense_write: assert property (
      @(posedge clk) disable iff (!rst_n)
      reg_wr && reg_addr == BKC_LOOP_OFFSET
      |=> freewheel_node_sense == $past(reg_wdata[BKC_NODE_SENSE_BIT]))
      else $error("node sense control not updated");

   a_pin_fast_gate: assert property (
      @(posedge clk) disable iff (!rst_n)
      !pin_two_fast_control && !fast_pretrigger |=> !fast_mode)
      else $error("input two reached fast mode while gated");

   a_pin_fast_on: assert property (
      @(posedge clk) disable iff (!rst_n)
      pin_two_fast_control && multipurpose_input_two |=> fast_mode)
      else $error("input two failed to set fast mode");

   a_mode_write: assert property (
      @(posedge clk) disable iff (!rst_n)
      reg_wr && reg_addr == BKC_MODE_OFFSET
      |=> forced_pwm == $past(reg_wdata[BKC_FPWM_BIT])
      && adaptive_peak_off == $past(reg_wdata[BKC_ADAPT_OFF_BIT]))
      else $error("mode controls not updated");

   a_peak_write: assert property (
      @(posedge clk) disable iff (!rst_n)
      reg_wr && reg_addr == BKC_PEAK_OFFSET
      |=> peak_table_bypass == $past(reg_wdata[BKC_TABLE_BYPASS_BIT])
      && peak_current_code == $past(reg_wdata[3:0]))
      else $error("peak current controls not updated");

   // The mode and peak registers each have their own set of unassigned bits
   a_mode_reserved: assert property (
      @(posedge clk) disable iff (!rst_n)
      reg_rd && reg_addr == BKC_MODE_OFFSET
      |=> reg_rvalid && (reg_rdata & ~BKC_MODE_MASK) == 8'h00)
      else $error("unassigned mode bits read nonzero");

   a_peak_reserved: assert property (
      @(posedge clk) disable iff (!rst_n)
      reg_rd && reg_addr == BKC_PEAK_OFFSET
      |=> reg_rvalid && (reg_rdata & ~BKC_PEAK_MASK) == 8'h00)
      else $error("unassigned peak bits read nonzero");

   a_unmapped_zero: assert property (
      @(posedge clk) disable iff (!rst_n)
      reg_rd && reg_addr != BKC_LOOP_OFFSET && reg_addr != BKC_MODE_OFFSET
      && reg_addr != BKC_PEAK_OFFSET |=> reg_rvalid && reg_rdata == 8'h00)
      else $error("unmapped address read nonzero");

   a_loop_readback: assert property (
      @(posedge clk) disable iff (!rst_n)
      reg_rd && reg_addr == BKC_LOOP_OFFSET
      |=> reg_rvalid && reg_rdata == $past(buck_one_loop_options))
      else $error("loop options read back wrong");

   a_rvalid_pulse: assert property (
      @(posedge clk) disable iff (!rst_n)
      !reg_rd |=> !reg_rvalid)
      else $error("read valid without a read");

   a_peak_hold: assert property (
      @(posedge clk) disable iff (!rst_n)
      !(reg_wr && reg_addr == BKC_PEAK_OFFSET)
      |=> $stable(buck_one_peak_current))
      else $error("peak current changed without a write");

   a_hold_no_write: assert property (
      @(posedge clk) disable iff (!rst_n)
      !(reg_wr && reg_addr == BKC_LOOP_OFFSET)
      |=> $stable(buck_one_loop_options))
      else $error("loop options changed without a write");

endmodule

// file: bkc_stage_model.sv
`timescale 1ns/1ps
module bkc_stage_model #(
   parameter int TABLE_MA = 100  // Arbitrary stand-in for the table value
) (
   input wire logic peak_table_bypass,       // Use code, no table
   input wire logic [3:0] peak_current_code, // Peak current code
   input wire logic passive_discharge,       // Passive discharge request
   input wire logic active_discharge,        // Active discharge request
   output logic [8:0] peak_ma,               // Peak current in force, mA
   output logic discharging                  // Output being discharged
);
   // Code only counts when the table is bypassed
   assign peak_ma = peak_table_bypass ? 9'(peak_current_code * 25) :
                    9'(TABLE_MA);
   assign discharging = passive_discharge | active_discharge;
endmodule

// file: test_buck_one_config_regs.sv
`timescale 1ns/1ps
module test_buck_one_config_regs;
   import bkc_pkg::*;
   localparam int TABLE_MA = 100;
   logic clk, rst_n, reg_wr, reg_rd, reg_rvalid, hard_reset;
   logic boot_enable, pin_enable, multipurpose_input_two;
   logic [7:0] reg_addr, reg_wdata, reg_rdata;
   logic [2:0] sequencing_select;
   logic [1:0] regulator_enable_field;
   logic integrator_off, power_good_during_transition, fast_pretrigger;
   logic fast_mode, passive_discharge, active_discharge, slow_edge_select;
   logic switch_halving, freewheel_node_sense, pin_two_fast_control;
   logic forced_pwm, adaptive_peak_off, peak_table_bypass, regulator_enable;
   logic discharging;
   logic [3:0] peak_current_code;
   logic [8:0] peak_ma;
   logic [7:0] en_case [7] = '{8'he9, 8'he6, 8'hf5, 8'hf2, 8'hfe, 8'h4b,
                               8'h4c};
   int n_errors, compares, cycles;

   bkc_config_regs u_dut (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
      .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
      .hard_reset(hard_reset), .sequencing_select(sequencing_select),
      .regulator_enable_field(regulator_enable_field),
      .boot_enable(boot_enable), .pin_enable(pin_enable),
      .multipurpose_input_two(multipurpose_input_two),
      .integrator_off(integrator_off),
      .power_good_during_transition(power_good_during_transition),
      .fast_pretrigger(fast_pretrigger), .fast_mode(fast_mode),
      .passive_discharge(passive_discharge),
      .active_discharge(active_discharge),
      .slow_edge_select(slow_edge_select), .switch_halving(switch_halving),
      .freewheel_node_sense(freewheel_node_sense),
      .pin_two_fast_control(pin_two_fast_control), .forced_pwm(forced_pwm),
      .adaptive_peak_off(adaptive_peak_off),
      .peak_table_bypass(peak_table_bypass),
      .peak_current_code(peak_current_code),
      .regulator_enable(regulator_enable));

   bkc_stage_model #(.TABLE_MA(TABLE_MA)) u_stage (
      .peak_table_bypass(peak_table_bypass),
      .peak_current_code(peak_current_code),
      .passive_discharge(passive_discharge),
      .active_discharge(active_discharge), .peak_ma(peak_ma),
      .discharging(discharging));

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      compares++;
      if (got !== exp) begin
         n_errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      check(16'(reg_rvalid), 16'h0001);
      check(16'(reg_rdata), 16'(exp));
   endtask

   // Let the edge's updates land before sampling
   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic end_test(input string name);
      $display("test %s done, errors so far %0d", name, n_errors);
   endtask

   task automatic wrap_up();
      $display("compares %0d errors %0d", compares, n_errors);
      if (n_errors == 0 && compares > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   // Cut a hang short well above the few hundred cycles the tests need
   always @(posedge clk) begin
      cycles++;
      if (cycles == 3000) begin
         n_errors++;
         $display("Error at %0t: got %h expected %h", $time, cycles, 0);
         wrap_up();
      end
   end

   initial begin
      rst_n = 1'b0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      hard_reset = 1'b0;
      sequencing_select = 3'h0;
      regulator_enable_field = 2'h0;
      boot_enable = 1'b0;
      pin_enable = 1'b0;
      multipurpose_input_two = 1'b0;
      step(10);
      check({passive_discharge, active_discharge}, 2'b11);
      @(posedge clk);
      rst_n <= 1'b1;
      rd(BKC_LOOP_OFFSET, 8'h00);
      rd(BKC_MODE_OFFSET, 8'h00);
      rd(BKC_PEAK_OFFSET, 8'h00);
      end_test("reset");

      for (int i = 0; i < 8; i++) begin
         wr(BKC_LOOP_OFFSET, 8'h01 << i);
         step(1);
         check({integrator_off, power_good_during_transition, fast_pretrigger,
                2'b00, slow_edge_select, switch_halving, freewheel_node_sense},
               (8'h01 << i) & 8'he7);
         check(16'(fast_mode), 16'(i == 5));
      end
      wr(BKC_LOOP_OFFSET, 8'ha5);
      rd(BKC_LOOP_OFFSET, 8'ha5);
      end_test("loop");

      for (int i = 3; i < 6; i++) begin
         wr(BKC_MODE_OFFSET, 8'h01 << i);
         step(1);
         check({pin_two_fast_control, forced_pwm, adaptive_peak_off},
               3'b001 << (i - 3));
      end
      wr(BKC_MODE_OFFSET, 8'hff);
      rd(BKC_MODE_OFFSET, 8'h38);
      wr(BKC_MODE_OFFSET, 8'hc7);
      rd(BKC_MODE_OFFSET, 8'h00);
      end_test("mode");

      wr(BKC_PEAK_OFFSET, 8'hff);
      rd(BKC_PEAK_OFFSET, 8'h8f);
      for (int c = 0; c < 16; c++) begin
         wr(BKC_PEAK_OFFSET, 8'h80 | 8'(c));
         step(1);
         check(16'(peak_ma), 16'(c * 25));
         check({peak_table_bypass, peak_current_code},
               5'h10 | 5'(c));
      end
      wr(BKC_PEAK_OFFSET, 8'h07);
      step(1);
      check(16'(peak_ma), 16'(TABLE_MA));
      wr(BKC_PEAK_OFFSET, 8'h87);
      end_test("peak");

      wr(BKC_LOOP_OFFSET, 8'h00);
      wr(BKC_MODE_OFFSET, 8'h00);
      multipurpose_input_two <= 1'b1;
      step(2);
      check(16'(fast_mode), 16'h0000);
      wr(BKC_MODE_OFFSET, 8'h20);
      step(2);
      check(16'(fast_mode), 16'h0001);
      @(posedge clk);
      multipurpose_input_two <= 1'b0;
      step(2);
      check(16'(fast_mode), 16'h0000);
      end_test("pin fast");

      for (int lv = 0; lv < 2; lv++) begin
         wr(BKC_LOOP_OFFSET, lv == 0 ? 8'h10 : 8'h08);
         for (int k = 0; k < 7; k++) begin
            @(posedge clk);
            sequencing_select <= en_case[k][7:5];
            regulator_enable_field <= en_case[k][4:3];
            pin_enable <= en_case[k][2];
            boot_enable <= en_case[k][1];
            step(3);
            check(16'(regulator_enable), 16'(en_case[k][0]));
            check({passive_discharge, active_discharge},
                  {lv == 0, lv == 1} & {2{~en_case[k][0]}});
         end
      end
      wr(BKC_LOOP_OFFSET, 8'h00);
      hard_reset <= 1'b1;
      step(2);
      check({passive_discharge, active_discharge}, 2'b11);
      check(16'(discharging), 16'h0001);
      @(posedge clk);
      hard_reset <= 1'b0;
      step(2);
      check({passive_discharge, active_discharge}, 2'b00);
      check(16'(discharging), 16'h0000);
      end_test("discharge");

      wr(8'h1f, 8'hff);
      rd(8'h1f, 8'h00);
      rd(BKC_LOOP_OFFSET, 8'h00);
      rd(BKC_PEAK_OFFSET, 8'h87);
      end_test("unmapped");
      wrap_up();
   end
endmodule
